/* File: tb/ioc_chk.sv */
// Purpose: Assertions on the cable between the two channel ends.
// Assumes: One clock, synchronous active-low reset.
// Notes: Watches the first link only.
module ioc_chk #(
  parameter int W = 12
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic [W-1:0] data, // Resolved data
  input wire logic [W/12-1:0] par, // Resolved parity
  input wire logic ch_oe, // Channel drives
  input wire logic eq_oe, // Equipment drives
  input wire logic connect, // Connect strobe
  input wire logic func, // Function strobe
  input wire logic dstb, // Data strobe
  input wire logic rd, // Read line
  input wire logic wr, // Write line
  input wire logic wmark, // Word mark
  input wire logic reply, // Reply
  input wire logic reject, // Reject
  input wire logic eor // End of record
);
  logic stb, rsp, conn_d_ff;
  logic [7:0] age_ff;
  assign stb = connect | func | dstb;
  assign rsp = reply | reject | eor;
  // ==========================================================
  // Cycles since connect rose
  always_ff @(posedge clk) begin
    conn_d_ff <= connect;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || (connect && !conn_d_ff)) begin
      age_ff <= 8'h00;
    end else if (age_ff != 8'hff) begin
      age_ff <= age_ff + 8'h01;
    end
  end
  // ==========================================================
  // Handshake checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  resp_holds_a: assert property (rsp && stb |=> rsp)
    else $error("response dropped under strobe");
  resp_drops_a: assert property (!stb [*7] |-> !rsp)
    else $error("response stuck after strobe fell");
  strobe_drops_a: assert property ($rose(rsp) |-> ##[1:10] !stb)
    else $error("strobe not dropped after response");
  conn_wait_a: assert property (
    $rose(reply | reject) && connect |-> age_ff >= 8'h50)
    else $error("connect answered too early");
  code_setup_a: assert property (
    $rose(connect | func | (dstb & wr)) |->
      ch_oe && $past(ch_oe, 8) && data == $past(data, 8))
    else $error("strobe before settled data");
  parity_ok_a: assert property (
    (ch_oe && (connect | func)) || (eq_oe && reply) |->
      par[0] == ~^data[11:0])
    else $error("bad parity on bus");
  eor_drops_rd_a: assert property ($rose(eor) |-> ##[1:10] !rd)
    else $error("read line kept after end of record");
  read_drive_a: assert property (rd && dstb && reply |-> eq_oe)
    else $error("read reply without data drive");
  one_resp_a: assert property ($onehot0({reply, reject, eor}))
    else $error("two responses at once");
  mark_pairs_a: assert property ($rose(wmark) |-> $rose(dstb))
    else $error("word mark apart from data strobe");
  cover property ($rose(reply) && connect);
  cover property ($rose(reject));
  cover property ($rose(eor));
  cover property ($rose(reply) && wr);
endmodule

/* File: tb/test_io_channel_handshake.sv */
// Purpose: Channel and equipment ends joined, plus a faulty second link.
// Assumes: 40 MHz clock, equipment number 3.
// Notes: Second link is driven by hand to break parity.
module test_io_channel_handshake;
  import ioc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n = 1'b0, ce = 1'b1, op_req = 1'b0, wr_last = 1'b0;
  ioc_op_e op_kind = OP_CONN;
  logic [11:0] op_code = 12'h000, cw_data = 12'h000, e_rd_data = 12'h000;
  logic rd_mode = 1'b0, wr_mode = 1'b0, avail = 1'b1, fn_ok = 1'b1;
  logic rd_valid = 1'b0, rd_eor = 1'b0, resp2_ff = 1'b0;
  logic [2:0] eq_num = 3'h3;
  logic op_done, rd_perr, connected, stat_en, wr_mark, perr, perr2;
  logic busy, fn_start, rd_take, wr_stb;
  int n_fs = 0, n_rt = 0, n_ws = 0;
  ioc_resp_e op_resp;
  logic [11:0] c_rd_data, fn_code, e_wr_data;
  logic [8:0] unit;
  int miscompares = 0, cmp_count = 0;
  ioc_if #(.W(12)) i1();
  ioc_if #(.W(12)) i2();
  ioc_chan #(.W(12), .TMO_CYC(200)) ioc_chan_inst (.clk(clk),
    .rst_n(rst_n), .ce(ce), .op_req(op_req), .op_kind(op_kind),
    .op_code(op_code), .rd_mode(rd_mode), .wr_mode(wr_mode),
    .wr_data(cw_data), .wr_last(wr_last), .busy(busy), .op_done(op_done),
    .op_resp(op_resp), .rd_data(c_rd_data), .rd_perr(rd_perr), .b(i1));
  ioc_equip #(.W(12)) ioc_equip_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .eq_num(eq_num), .avail(avail), .fn_ok(fn_ok), .rd_data(e_rd_data),
    .rd_valid(rd_valid), .rd_eor(rd_eor), .connected(connected),
    .stat_en(stat_en), .unit(unit), .fn_start(fn_start),
    .fn_code(fn_code), .rd_take(rd_take), .wr_stb(wr_stb),
    .wr_data(e_wr_data), .wr_mark(wr_mark),
    .perr(perr), .b(i1));
  ioc_equip #(.W(12)) ioc_equip_inst2 (.clk(clk), .rst_n(rst_n), .ce(ce),
    .eq_num(eq_num), .avail(avail), .fn_ok(fn_ok), .rd_data(e_rd_data),
    .rd_valid(rd_valid), .rd_eor(rd_eor), .connected(), .stat_en(),
    .unit(), .fn_start(), .fn_code(), .rd_take(), .wr_stb(), .wr_data(),
    .wr_mark(), .perr(perr2), .b(i2));
  ioc_chk #(.W(12)) ioc_chk_inst (.clk(clk), .rst_n(rst_n),
    .data(i1.data), .par(i1.par), .ch_oe(i1.ch_oe), .eq_oe(i1.eq_oe),
    .connect(i1.connect), .func(i1.func), .dstb(i1.dstb), .rd(i1.rd),
    .wr(i1.wr), .wmark(i1.wmark), .reply(i1.reply),
    .reject(i1.reject), .eor(i1.eor));
  // ==========================================================
  // Clock, watchdog, second-link monitor
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  always @(posedge clk) begin
    if (i2.reply | i2.reject) begin
      resp2_ff <= 1'b1;
    end
    if (fn_start) begin
      n_fs <= n_fs + 1;
    end
    if (rd_take) begin
      n_rt <= n_rt + 1;
    end
    if (wr_stb) begin
      n_ws <= n_ws + 1;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic chk_resp(input ioc_resp_e e);
    chk("op_resp", 12'(e), 12'(op_resp));
  endtask
  task automatic do_op(input ioc_op_e k, input logic [11:0] c,
                       input logic l);
    int n;
    @(posedge clk);
    op_req <= 1'b1;
    op_kind <= k;
    op_code <= c;
    cw_data <= c;
    wr_last <= l;
    @(posedge clk);
    op_req <= 1'b0;
    #1;
    n = 0;
    while (op_done !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("op_done", 12'h001, 12'(op_done));
  endtask
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_connect();
    do_op(OP_CONN, {3'h3, 9'h05a}, 1'b0);
    chk_resp(R_REPLY);
    chk("connected", 12'h001, 12'(connected));
    chk("unit", 12'h05a, 12'(unit));
    chk("perr", 12'h000, 12'(perr));
  endtask
  task automatic t_func();
    @(posedge clk);
    fn_ok <= 1'b0;
    do_op(OP_FUNC, 12'h123, 1'b0);
    chk_resp(R_REJECT);
    fn_ok <= 1'b1;
    do_op(OP_FUNC, 12'h456, 1'b0);
    chk_resp(R_REPLY);
    chk("fn_code", 12'h456, fn_code);
    chk("fn_start count", 12'h001, 12'(n_fs));
  endtask
  task automatic t_write();
    @(posedge clk);
    wr_mode <= 1'b1;
    do_op(OP_DATA, 12'ha5c, 1'b1);
    chk_resp(R_REPLY);
    chk("wr_data", 12'ha5c, e_wr_data);
    chk("wr_mark", 12'h001, 12'(wr_mark));
    chk("wr line", 12'h001, 12'(i1.wr));
    do_op(OP_DATA, 12'h3c0, 1'b0);
    chk("wr_data", 12'h3c0, e_wr_data);
    chk("wr_mark", 12'h000, 12'(wr_mark));
    chk("wr_stb count", 12'h002, 12'(n_ws));
    wr_mode <= 1'b0;
  endtask
  task automatic t_read();
    @(posedge clk);
    rd_mode <= 1'b1;
    rd_valid <= 1'b1;
    e_rd_data <= 12'h7e1;
    do_op(OP_DATA, 12'h000, 1'b0);
    chk_resp(R_REPLY);
    chk("rd_data", 12'h7e1, c_rd_data);
    chk("rd_perr", 12'h000, 12'(rd_perr));
    chk("rd_take count", 12'h001, 12'(n_rt));
    rd_valid <= 1'b0;
    rd_eor <= 1'b1;
    do_op(OP_DATA, 12'h000, 1'b0);
    chk_resp(R_EOR);
    chk("rd line", 12'h000, 12'(i1.rd));
    rd_eor <= 1'b0;
    rd_mode <= 1'b0;
  endtask
  task automatic t_foreign();
    fork
      do_op(OP_CONN, {3'h5, 9'h000}, 1'b0);
      begin
        repeat (48) @(posedge clk);
        #1;
        chk("connected", 12'h000, 12'(connected));
      end
    join
    chk_resp(R_TMO);
    chk("stat_en", 12'h000, 12'(stat_en));
    do_op(OP_FUNC, 12'h456, 1'b0);
    chk_resp(R_TMO);
  endtask
  task automatic t_notavail();
    @(posedge clk);
    avail <= 1'b0;
    do_op(OP_CONN, {3'h3, 9'h001}, 1'b0);
    chk_resp(R_REJECT);
    chk("stat_en", 12'h001, 12'(stat_en));
    chk("connected", 12'h000, 12'(connected));
    avail <= 1'b1;
  endtask
  task automatic t_freeze();
    fork
      do_op(OP_CONN, {3'h3, 9'h022}, 1'b0);
      begin
        repeat (40) @(posedge clk);
        ce <= 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk("reply in freeze", 12'h000, 12'(i1.reply));
        chk("busy", 12'h001, 12'(busy));
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk_resp(R_REPLY);
    chk("unit", 12'h022, 12'(unit));
    chk("connected", 12'h001, 12'(connected));
  endtask
  task automatic t_badpar();
    @(posedge clk);
    i2.ch_dout <= 12'h6a5;
    i2.ch_pout <= ^12'h6a5;
    i2.ch_oe <= 1'b1;
    repeat (8) @(posedge clk);
    i2.connect <= 1'b1;
    repeat (150) @(posedge clk);
    i2.connect <= 1'b0;
    i2.ch_oe <= 1'b0;
    #1;
    chk("answer on bad code", 12'h000, 12'(resp2_ff));
    chk("perr2", 12'h001, 12'(perr2));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    i2.ch_dout = 12'h000;
    i2.ch_pout = 1'b0;
    i2.ch_oe = 1'b0;
    {i2.connect, i2.func, i2.dstb, i2.rd, i2.wr, i2.wmark} = 6'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_connect();
    t_func();
    t_write();
    t_read();
    t_foreign();
    t_notavail();
    t_freeze();
    t_badpar();
    complete_run();
  end
endmodule

/* File: verilog/ioc_chan.sv */
// Purpose: Data channel end: connect, function, data transfers.
// Assumes: One request at a time, taken while not busy.
// Notes: Internal timeout answer (R_TMO) after the no-answer timeout.
`include "ioc_map.svh"
module ioc_chan
  import ioc_pkg::*;
#(
  parameter int W = `IOC_BYTE_W,
  parameter int TMO_CYC = `IOC_TMO_CYC
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic op_req, // Start request
  input wire ioc_op_e op_kind, // Request kind
  input wire logic [11:0] op_code, // Connect or function code
  input wire logic rd_mode, // Read operation active
  input wire logic wr_mode, // Write operation active
  input wire logic [W-1:0] wr_data, // Write byte
  input wire logic wr_last, // Final byte of word
  output logic busy, // Request in progress
  output logic op_done, // Request finished
  output ioc_resp_e op_resp, // Answer seen
  output logic [W-1:0] rd_data, // Read byte
  output logic rd_perr, // Read byte parity bad
  ioc_if.chan b // Cable
);
  localparam int NP = W / `IOC_BYTE_W;
  ioc_cst_e st_ff;
  ioc_op_e kind_ff;
  logic [2:0] rs1_ff, rs2_ff, rs3_ff, rf_ff;
  logic [W+NP-1:0] ds1_ff, ds2_ff;
  logic [`IOC_CNT_W-1:0] cnt_ff;
  logic eor_seen_ff, rd_ff, wr_ff, busy_ff, done_ff, perr_ff, oe_ff;
  logic cn_ff, fn_ff, ds_ff, wm_ff, last_ff;
  logic [W-1:0] dout_ff, rdat_ff;
  logic [NP-1:0] pgen, pchk;
  ioc_resp_e resp_ff;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_par
      assign pgen[g] = ioc_odd_par(dout_ff[g*`IOC_BYTE_W +: `IOC_BYTE_W]);
      assign pchk[g] = ioc_odd_par(ds2_ff[g*`IOC_BYTE_W +: `IOC_BYTE_W]);
    end
  endgenerate

  // ==========================================
  // Input synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs1_ff <= '0;
      rs2_ff <= '0;
      rs3_ff <= '0;
      rf_ff <= '0;
      ds1_ff <= '0;
      ds2_ff <= '0;
    end else if (ce) begin
      rs1_ff <= {b.eor, b.reject, b.reply};
      rs2_ff <= rs1_ff;
      rs3_ff <= rs2_ff;
      rf_ff <= (rs2_ff & rs3_ff) | (rf_ff & (rs2_ff | rs3_ff));
      ds1_ff <= {b.par, b.data};
      ds2_ff <= ds1_ff;
    end
  end

  // ==========================================
  // Operation lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      eor_seen_ff <= 1'b0;
    end else if (ce) begin
      if (!rd_mode)
        eor_seen_ff <= 1'b0;
      else if (st_ff == C_STB && rf_ff[`IOC_EO])
        eor_seen_ff <= 1'b1;
      rd_ff <= rd_mode && !eor_seen_ff && !rf_ff[`IOC_EO];
      wr_ff <= wr_mode;
    end
  end

  // ==========================================
  // Request sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= C_IDLE;
      kind_ff <= OP_CONN;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      resp_ff <= R_NONE;
      oe_ff <= 1'b0;
      dout_ff <= '0;
      cn_ff <= 1'b0;
      fn_ff <= 1'b0;
      ds_ff <= 1'b0;
      wm_ff <= 1'b0;
      last_ff <= 1'b0;
      rdat_ff <= '0;
      perr_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= 1'b0;
      cnt_ff <= cnt_ff + 1'b1;
      unique case (st_ff)
        C_IDLE: begin
          cnt_ff <= '0;
          if (op_req) begin
            kind_ff <= op_kind;
            busy_ff <= 1'b1;
            last_ff <= wr_last;
            st_ff <= C_SETUP;
            if (op_kind == OP_DATA) begin
              oe_ff <= wr_mode && !rd_mode;
              dout_ff <= wr_data;
            end else begin
              oe_ff <= 1'b1;
              dout_ff <= W'(op_code);
            end
          end
        end
        C_SETUP: begin
          if (cnt_ff == `IOC_CNT_W'(`IOC_SETUP_CYC - 1)) begin
            cnt_ff <= '0;
            st_ff <= C_STB;
            cn_ff <= kind_ff == OP_CONN;
            fn_ff <= kind_ff == OP_FUNC;
            ds_ff <= kind_ff == OP_DATA;
            wm_ff <= kind_ff == OP_DATA && last_ff;
          end
        end
        C_STB: begin
          if (rf_ff != 3'b000 || cnt_ff == `IOC_CNT_W'(TMO_CYC - 1)) begin
            cn_ff <= 1'b0;
            fn_ff <= 1'b0;
            ds_ff <= 1'b0;
            wm_ff <= 1'b0;
            st_ff <= C_DROP;
            if (rf_ff[`IOC_EO])
              resp_ff <= R_EOR;
            else if (rf_ff[`IOC_RJ])
              resp_ff <= R_REJECT;
            else if (rf_ff[`IOC_RP])
              resp_ff <= R_REPLY;
            else
              resp_ff <= R_TMO;
            if (rf_ff[`IOC_RP] && !oe_ff) begin
              rdat_ff <= ds2_ff[W-1:0];
              perr_ff <= pchk != ds2_ff[W +: NP];
            end
          end
        end
        C_DROP: begin
          if (rf_ff == 3'b000) begin
            oe_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            st_ff <= C_IDLE;
          end
        end
      endcase
    end
  end

  assign busy = busy_ff;
  assign op_done = done_ff;
  assign op_resp = resp_ff;
  assign rd_data = rdat_ff;
  assign rd_perr = perr_ff;
  assign b.ch_dout = dout_ff;
  assign b.ch_pout = pgen;
  assign b.ch_oe = oe_ff;
  assign b.connect = cn_ff;
  assign b.func = fn_ff;
  assign b.dstb = ds_ff;
  assign b.wmark = wm_ff;
  assign b.rd = rd_ff;
  assign b.wr = wr_ff;
endmodule

/* File: verilog/ioc_equip.sv */
// Purpose: External equipment end of the I/O channel handshake.
// Assumes: Switch number and user inputs are on this clock.
// Notes: Every cable control input is filtered before use; data and parity are only resynchronised.
`include "ioc_map.svh"
module ioc_equip
  import ioc_pkg::*;
#(
  parameter int W = `IOC_BYTE_W
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic [2:0] eq_num, // Equipment number switch
  input wire logic avail, // Free for connection
  input wire logic fn_ok, // Can run a function now
  input wire logic [W-1:0] rd_data, // Word to send on read
  input wire logic rd_valid, // Read word ready
  input wire logic rd_eor, // End of record reached
  output logic connected, // Equipment connected
  output logic stat_en, // Status lines enabled
  output logic [8:0] unit, // Selected unit
  output logic fn_start, // Function accepted
  output logic [11:0] fn_code, // Accepted function code
  output logic rd_take, // Read word consumed
  output logic wr_stb, // Write byte captured
  output logic [W-1:0] wr_data, // Captured write byte
  output logic wr_mark, // Captured byte ends word
  output logic perr, // Transmission parity error
  ioc_if.equip b // Cable
);
  localparam int NP = W / `IOC_BYTE_W;
  ioc_dst_e st_ff;
  logic [5:0] cs1_ff, cs2_ff, cs3_ff, cf_ff, cfq_ff;
  logic [W+NP-1:0] ds1_ff, ds2_ff;
  logic [`IOC_CNT_W-1:0] cnt_ff;
  logic [NP-1:0] pgen, pchk;
  logic [5:0] rise;
  logic code_ok, data_ok, mine, perr_set;
  logic conn_ff, stat_ff, pend_rj_ff, perr_ff;
  logic rp_ff, rj_ff, eo_ff, oe_ff;
  logic fs_ff, rt_ff, ws_ff, wm_ff;
  logic [8:0] unit_ff;
  logic [11:0] fcode_ff;
  logic [W-1:0] dout_ff, wdat_ff;
  logic [NP-1:0] pout_ff;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_par
      assign pgen[g] = ioc_odd_par(rd_data[g*`IOC_BYTE_W +: `IOC_BYTE_W]);
      assign pchk[g] = ioc_odd_par(ds2_ff[g*`IOC_BYTE_W +: `IOC_BYTE_W]);
    end
  endgenerate

  assign rise = cf_ff & ~cfq_ff;
  assign code_ok = pchk[0] == ds2_ff[W];
  assign data_ok = pchk == ds2_ff[W +: NP];
  assign mine = ds2_ff[`IOC_EQ_HI:`IOC_EQ_LO] == eq_num;
  assign perr_set = st_ff == D_IDLE && (
    (rise[`IOC_CN] && !code_ok) ||
    (rise[`IOC_FN] && conn_ff && !code_ok) ||
    (rise[`IOC_DS] && conn_ff && cf_ff[`IOC_WR] && !data_ok));

  // ==========================================
  // Input synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs1_ff <= '0;
      cs2_ff <= '0;
      cs3_ff <= '0;
      cf_ff <= '0;
      cfq_ff <= '0;
      ds1_ff <= '0;
      ds2_ff <= '0;
    end else if (ce) begin
      cs1_ff <= {b.wmark, b.wr, b.rd, b.dstb, b.func, b.connect};
      cs2_ff <= cs1_ff;
      cs3_ff <= cs2_ff;
      cf_ff <= (cs2_ff & cs3_ff) | (cf_ff & (cs2_ff | cs3_ff));
      cfq_ff <= cf_ff;
      ds1_ff <= {b.par, b.data};
      ds2_ff <= ds1_ff;
    end
  end

  // ==========================================
  // Parity error flag
  always_ff @(posedge clk) begin
    if (!rst_n)
      perr_ff <= 1'b0;
    else if (ce) begin
      if (perr_set)
        perr_ff <= 1'b1;
      else if (st_ff == D_IDLE && rise[`IOC_CN])
        perr_ff <= 1'b0;
    end
  end

  // ==========================================
  // Connection state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conn_ff <= 1'b0;
      stat_ff <= 1'b0;
      unit_ff <= '0;
      pend_rj_ff <= 1'b0;
    end else if (ce && st_ff == D_IDLE && rise[`IOC_CN] && code_ok) begin
      if (mine) begin
        conn_ff <= avail;
        pend_rj_ff <= !avail;
        stat_ff <= 1'b1;
        unit_ff <= ds2_ff[`IOC_UNIT_HI:0];
      end else begin
        conn_ff <= 1'b0;
        stat_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // Response sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= D_IDLE;
      cnt_ff <= '0;
      rp_ff <= 1'b0;
      rj_ff <= 1'b0;
      eo_ff <= 1'b0;
      oe_ff <= 1'b0;
      dout_ff <= '0;
      pout_ff <= '0;
      fs_ff <= 1'b0;
      rt_ff <= 1'b0;
      ws_ff <= 1'b0;
      wm_ff <= 1'b0;
      fcode_ff <= '0;
      wdat_ff <= '0;
    end else if (ce) begin
      fs_ff <= 1'b0;
      rt_ff <= 1'b0;
      ws_ff <= 1'b0;
      unique case (st_ff)
        D_IDLE: begin
          cnt_ff <= '0;
          if (rise[`IOC_CN]) begin
            if (code_ok && mine)
              st_ff <= D_CWAIT;
          end else if (rise[`IOC_FN] && conn_ff) begin
            st_ff <= D_HOLD;
            if (code_ok && fn_ok) begin
              rp_ff <= 1'b1;
              fs_ff <= 1'b1;
              fcode_ff <= ds2_ff[11:0];
            end else
              rj_ff <= 1'b1;
          end else if (rise[`IOC_DS] && conn_ff) begin
            if (cf_ff[`IOC_RD])
              st_ff <= D_RDWAIT;
            else if (cf_ff[`IOC_WR]) begin
              wdat_ff <= ds2_ff[W-1:0];
              wm_ff <= cf_ff[`IOC_WM];
              ws_ff <= 1'b1;
              rp_ff <= 1'b1;
              st_ff <= D_HOLD;
            end
          end
        end
        D_CWAIT: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == `IOC_CNT_W'(`IOC_CONN_MIN_CYC - 1)) begin
            rp_ff <= !pend_rj_ff;
            rj_ff <= pend_rj_ff;
            st_ff <= D_HOLD;
          end
        end
        D_RDWAIT: begin
          if (!cf_ff[`IOC_DS] || !cf_ff[`IOC_RD])
            st_ff <= D_IDLE;
          else if (rd_eor) begin
            eo_ff <= 1'b1;
            st_ff <= D_HOLD;
          end else if (rd_valid) begin
            dout_ff <= rd_data;
            pout_ff <= pgen;
            oe_ff <= 1'b1;
            rp_ff <= 1'b1;
            rt_ff <= 1'b1;
            st_ff <= D_HOLD;
          end
        end
        D_HOLD: begin
          if (cf_ff[`IOC_DS:`IOC_CN] == 3'b000) begin
            rp_ff <= 1'b0;
            rj_ff <= 1'b0;
            eo_ff <= 1'b0;
            oe_ff <= 1'b0;
            st_ff <= D_IDLE;
          end
        end
      endcase
    end
  end

  assign connected = conn_ff;
  assign stat_en = stat_ff;
  assign unit = unit_ff;
  assign fn_start = fs_ff;
  assign fn_code = fcode_ff;
  assign rd_take = rt_ff;
  assign wr_stb = ws_ff;
  assign wr_data = wdat_ff;
  assign wr_mark = wm_ff;
  assign perr = perr_ff;
  assign b.eq_dout = dout_ff;
  assign b.eq_pout = pout_ff;
  assign b.eq_oe = oe_ff;
  assign b.reply = rp_ff;
  assign b.reject = rj_ff;
  assign b.eor = eo_ff;
endmodule

/* File: verilog/ioc_if.sv */
// Purpose: Shared cable between channel and equipment.
// Assumes: At most one end enables the data lines.
// Notes: Bus level resolved from the equipment enable alone.
interface ioc_if #(parameter int W = 12);
  localparam int NP = W / 12;
  logic [W-1:0] ch_dout;
  logic [NP-1:0] ch_pout;
  logic ch_oe;
  logic [W-1:0] eq_dout;
  logic [NP-1:0] eq_pout;
  logic eq_oe;
  logic [W-1:0] data;
  logic [NP-1:0] par;
  logic connect, func, dstb, rd, wr, wmark;
  logic reply, reject, eor;
  assign data = eq_oe ? eq_dout : ch_dout;
  assign par = eq_oe ? eq_pout : ch_pout;
  modport chan (output ch_dout, ch_pout, ch_oe, connect, func, dstb, rd,
    wr, wmark, input data, par, reply, reject, eor);
  modport equip (output eq_dout, eq_pout, eq_oe, reply, reject, eor,
    input data, par, connect, func, dstb, rd, wr, wmark);
endinterface

/* File: verilog/ioc_map.svh */
// Purpose: Constants for the parallel I/O channel handshake.
// Assumes: 40 MHz clock on both ends.
// Notes: Cycle counts derive from the times below.
// Functional notes
// - Data moves in 12, 24 or 48-bit bytes
// - Eight equipments share request and code lines
// - Code top 3 bits equipment, low 9 unit
// - Channel settles code before connect strobe
// - Selected equipment replies if available, else rejects
// - Channel settles function code before function strobe
// - Equipment replies and starts function, else rejects
// - Read line high for whole read
// - Read strobe only when channel accepts word
// - Read word ready: drive data, assert reply
// - End of record replaces reply; read drops
// - Word mark with strobe on final byte
// - Write line high for whole write
// - Write strobe only after data valid
// - Equipment captures write data, then replies
// - Channel drops strobe after any response
// - Equipment holds response until strobe falls
// - Bad connect parity: no response, flag error
// - Foreign connect code disconnects within 1 us
// - No connect answer before 2 us
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH
`define IOC_BYTE_W 12
`define IOC_EQ_HI 11
`define IOC_EQ_LO 9
`define IOC_UNIT_HI 8
`define IOC_CLK_NS 25
`define IOC_SETUP_NS 200
`define IOC_SETUP_CYC ((`IOC_SETUP_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_CONN_MIN_NS 2000
`define IOC_CONN_MIN_CYC \
  ((`IOC_CONN_MIN_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_DISC_MAX_NS 1000
`define IOC_TMO_NS 100000
`define IOC_TMO_CYC (`IOC_TMO_NS / `IOC_CLK_NS)
`define IOC_CNT_W 12
`define IOC_CN 0
`define IOC_FN 1
`define IOC_DS 2
`define IOC_RD 3
`define IOC_WR 4
`define IOC_WM 5
`define IOC_RP 0
`define IOC_RJ 1
`define IOC_EO 2
`endif

/* File: verilog/ioc_pkg.sv */
// Purpose: Types shared by both channel ends.
// Assumes: Nothing beyond the constants header.
// Notes: Parity helper covers one 12-bit group.
package ioc_pkg;
  typedef enum logic [1:0] {D_IDLE, D_CWAIT, D_RDWAIT, D_HOLD} ioc_dst_e;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STB, C_DROP} ioc_cst_e;
  typedef enum logic [1:0] {OP_CONN, OP_FUNC, OP_DATA} ioc_op_e;
  typedef enum logic [2:0] {
    R_NONE, R_REPLY, R_REJECT, R_EOR, R_TMO
  } ioc_resp_e;
  function automatic logic ioc_odd_par(input logic [11:0] g);
    return ~^g;
  endfunction
endpackage
